// ---- common/dxmr_pkg.sv ----
// Overview of operation
// - command strobes low, BA1 low, BA0 high loads A0..A12 into register one
// - command strobes low, BA1 high, BA0 low loads A0..A12 into register two
// - register one: DLL, half drive, termination, additive latency, calibration, strobe disable
// - DLL switches off in self refresh and back on at its exit
// - register two bit A7 selects faster self refresh above 85 degrees
// - partial array self refresh loses unselected data once self refresh entered
// - A9..A7 code: 000 exit, 001 drive high, 010 drive low, 100 adjust, 111 default
// - drive high: DQ and strobe high, complement low; drive low the opposite
// - adjust code, first bit time first, steps pull-up and pull-down settings
// - each setting has 16 steps, saturates, and applies to all DQ alike
// - burst length lives in base mode register bits A2..A0
// - termination A6,A2: 01 gives 75, 10 gives 150, 11 gives 50 ohms
package dxmr_pkg;

  localparam int          ADDR_W       = 13;
  localparam int          DQ_W         = 16;
  localparam int          STEP_W       = 4;
  localparam logic [1:0]  BANK_BASE    = 2'h0;
  localparam logic [1:0]  BANK_ONE     = 2'h1;
  localparam logic [1:0]  BANK_TWO     = 2'h2;
  localparam logic [1:0]  BANK_THREE   = 2'h3;
  localparam int          DLL_OFF_BIT  = 0;
  localparam int          HALF_BIT     = 1;
  localparam int          RTT_LO_BIT   = 2;
  localparam int          AL_LSB       = 3;
  localparam int          RTT_HI_BIT   = 6;
  localparam int          OCD_LSB      = 7;
  localparam int          STRB_DIS_BIT = 10;
  localparam int          FAST_SR_BIT  = 7;
  localparam int          BL_LSB       = 0;
  localparam logic [2:0]  OCD_EXIT_C   = 3'h0;
  localparam logic [2:0]  OCD_DRV1_C   = 3'h1;
  localparam logic [2:0]  OCD_DRV0_C   = 3'h2;
  localparam logic [2:0]  OCD_ADJ_C    = 3'h4;
  localparam logic [2:0]  OCD_DEF_C    = 3'h7;
  localparam logic [12:0] REG_RESET    = 13'h0000;
  localparam logic [3:0]  STEP_DEFAULT = 4'h8;
  localparam logic [3:0]  STEP_MAX     = 4'hf;
  localparam logic [3:0]  STEP_MIN     = 4'h0;
  localparam logic [1:0]  BEAT_LAST    = 2'h3;

  typedef enum logic [2:0] {OCD_EXIT, OCD_DRIVE_HIGH, OCD_DRIVE_LOW, OCD_ADJUST,
                            OCD_DEFAULT} dxmr_ocd_type;
  typedef enum logic [1:0] {RTT_OFF, RTT_75, RTT_150, RTT_50} dxmr_rtt_type;
  typedef enum logic [0:0] {CAP_IDLE, CAP_BEATS} dxmr_cap_type;

  typedef struct packed {
    logic            cke;
    logic            cs_n;
    logic            ras_n;
    logic            cas_n;
    logic            we_n;
    logic [1:0]      ba;
    logic [12:0]     addr;
  } dxmr_cmd_type;

  typedef struct packed {
    logic [15:0]     dq;
    logic            dq_oe_n;
    logic [1:0]      dqs;
    logic [1:0]      dqs_n;
    logic            dqs_oe_n;
  } dxmr_drive_type;

  typedef struct packed {
    logic            up_inc;
    logic            up_dec;
    logic            dn_inc;
    logic            dn_dec;
  } dxmr_step_type;

endpackage

// ---- logic/dxmr_core.sv ----
module dxmr_core
  import dxmr_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           rstn_in,
  input  wire dxmr_cmd_type   cmd_in,
  input  wire logic [15:0]    dq_in,
  output logic [12:0]         ext_one_out,
  output logic [12:0]         ext_two_out,
  output logic [12:0]         ext_three_out,
  output logic [2:0]          burst_length_out,
  output logic                dll_active_out,
  output logic                half_strength_out,
  output dxmr_rtt_type        rtt_out,
  output logic [2:0]          additive_latency_out,
  output logic                strobe_compl_disable_out,
  output logic                fast_refresh_out,
  output logic [2:0]          partial_array_self_refresh_out,
  output logic                retention_lost_out,
  output logic                self_refresh_out,
  output dxmr_ocd_type        ocd_mode_out,
  output logic [3:0]          pull_up_out,
  output logic [3:0]          pull_down_out,
  output dxmr_drive_type      drive_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [12:0]     base_mode;
    logic [12:0]     ext_one;
    logic [12:0]     ext_two;
    logic [12:0]     ext_three;
    logic            cke_prev;
    logic            self_ref;
    logic            lost;
    logic            dll_on;
    dxmr_rtt_type    rtt;
    dxmr_ocd_type    ocd;
    dxmr_cap_type    cap;
    logic [1:0]      beat;
    logic [3:0]      code;
    logic [3:0]      pull_up;
    logic [3:0]      pull_down;
    dxmr_drive_type  drv;
  } dxmr_state_type;

  dxmr_state_type st_r;
  dxmr_state_type st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [3:0] sat_step(input logic [3:0] v, input logic inc,
                                          input logic dec);
    logic [3:0] r;
    r = v;
    if (inc && v != STEP_MAX) begin
      r = v + 4'h1;
    end else if (dec && v != STEP_MIN) begin
      r = v - 4'h1;
    end
    return r;
  endfunction

  function automatic dxmr_step_type adj_decode(input logic [3:0] c);
    dxmr_step_type s;
    s = '0;
    case (c)
      4'h1: s.up_inc = 1'b1;
      4'h2: s.up_dec = 1'b1;
      4'h4: s.dn_inc = 1'b1;
      4'h8: s.dn_dec = 1'b1;
      4'h5: begin
        s.up_inc = 1'b1;
        s.dn_inc = 1'b1;
      end
      4'h6: begin
        s.up_dec = 1'b1;
        s.dn_inc = 1'b1;
      end
      4'h9: begin
        s.up_inc = 1'b1;
        s.dn_dec = 1'b1;
      end
      4'ha: begin
        s.up_dec = 1'b1;
        s.dn_dec = 1'b1;
      end
      default: s = '0;
    endcase
    return s;
  endfunction

  function automatic dxmr_rtt_type rtt_decode(input logic hi, input logic lo);
    dxmr_rtt_type r;
    case ({hi, lo})
      2'h1:    r = RTT_75;
      2'h2:    r = RTT_150;
      2'h3:    r = RTT_50;
      default: r = RTT_OFF;
    endcase
    return r;
  endfunction

  function automatic dxmr_drive_type drive_for(input dxmr_ocd_type m);
    dxmr_drive_type d;
    d.dq       = '0;
    d.dq_oe_n  = 1'b1;
    d.dqs      = '0;
    d.dqs_n    = '0;
    d.dqs_oe_n = 1'b1;
    if (m == OCD_DRIVE_HIGH) begin
      d.dq       = '1;
      d.dqs      = '1;
      d.dqs_n    = '0;
      d.dq_oe_n  = 1'b0;
      d.dqs_oe_n = 1'b0;
    end else if (m == OCD_DRIVE_LOW) begin
      d.dq       = '0;
      d.dqs      = '0;
      d.dqs_n    = '1;
      d.dq_oe_n  = 1'b0;
      d.dqs_oe_n = 1'b0;
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  logic          mrs_cmd;
  logic          wr_one;
  logic          wr_two;
  logic          wr_three;
  logic          wr_base;
  logic          sr_entry;
  logic          wr_data;
  logic [2:0]    ocd_code;

  assign mrs_cmd  = cmd_in.cke && !cmd_in.cs_n && !cmd_in.ras_n && !cmd_in.cas_n
                    && !cmd_in.we_n;
  assign wr_base  = mrs_cmd && cmd_in.ba == BANK_BASE;
  assign wr_one   = mrs_cmd && cmd_in.ba == BANK_ONE;
  assign wr_two   = mrs_cmd && cmd_in.ba == BANK_TWO;
  assign wr_three = mrs_cmd && cmd_in.ba == BANK_THREE;
  assign sr_entry = st_r.cke_prev && !cmd_in.cke && !cmd_in.cs_n && !cmd_in.ras_n
                    && !cmd_in.cas_n && cmd_in.we_n;
  assign wr_data  = cmd_in.cke && !cmd_in.cs_n && cmd_in.ras_n && !cmd_in.cas_n
                    && !cmd_in.we_n;
  assign ocd_code = cmd_in.addr[OCD_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    dxmr_step_type sd;
    sd = '0;
    st_nxt = st_r;
    st_nxt.cke_prev = cmd_in.cke;
    if (wr_base) begin
      st_nxt.base_mode = cmd_in.addr;
    end
    if (wr_one) begin
      st_nxt.ext_one = cmd_in.addr;
      st_nxt.rtt = rtt_decode(cmd_in.addr[RTT_HI_BIT], cmd_in.addr[RTT_LO_BIT]);
      case (ocd_code)
        OCD_EXIT_C: st_nxt.ocd = OCD_EXIT;
        OCD_DRV1_C: st_nxt.ocd = OCD_DRIVE_HIGH;
        OCD_DRV0_C: st_nxt.ocd = OCD_DRIVE_LOW;
        OCD_ADJ_C:  st_nxt.ocd = OCD_ADJUST;
        OCD_DEF_C: begin
          st_nxt.ocd       = OCD_DEFAULT;
          st_nxt.pull_up   = STEP_DEFAULT;
          st_nxt.pull_down = STEP_DEFAULT;
        end
        default:    st_nxt.ocd = st_r.ocd;
      endcase
      st_nxt.cap = CAP_IDLE;
    end
    if (wr_two) begin
      st_nxt.ext_two = cmd_in.addr;
    end
    if (wr_three) begin
      st_nxt.ext_three = cmd_in.addr;
    end
    if (sr_entry) begin
      st_nxt.self_ref = 1'b1;
      if (st_r.ext_two[2:0] != 3'h0) begin
        st_nxt.lost = 1'b1;
      end
    end else if (st_r.self_ref && cmd_in.cke) begin
      st_nxt.self_ref = 1'b0;
    end
    st_nxt.dll_on = !st_nxt.ext_one[DLL_OFF_BIT] && !st_nxt.self_ref;
    case (st_r.cap)
      CAP_IDLE: begin
        if (st_r.ocd == OCD_ADJUST && wr_data && !wr_one) begin
          st_nxt.cap  = CAP_BEATS;
          st_nxt.beat = 2'h0;
        end
      end
      CAP_BEATS: begin
        if (!wr_one) begin
          st_nxt.code = {st_r.code[2:0], dq_in[0]};
          st_nxt.beat = st_r.beat + 2'h1;
          if (st_r.beat == BEAT_LAST) begin
            sd = adj_decode({st_r.code[2:0], dq_in[0]});
            st_nxt.pull_up   = sat_step(st_r.pull_up, sd.up_inc, sd.up_dec);
            st_nxt.pull_down = sat_step(st_r.pull_down, sd.dn_inc, sd.dn_dec);
            st_nxt.cap = CAP_IDLE;
          end
        end
      end
      default: st_nxt.cap = CAP_IDLE;
    endcase
    st_nxt.drv = drive_for(st_nxt.ocd);
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_r.base_mode <= REG_RESET;
      st_r.ext_one   <= REG_RESET;
      st_r.ext_two   <= REG_RESET;
      st_r.ext_three <= REG_RESET;
      st_r.cke_prev  <= 1'b0;
      st_r.self_ref  <= 1'b0;
      st_r.lost      <= 1'b0;
      st_r.dll_on    <= 1'b0;
      st_r.rtt       <= RTT_OFF;
      st_r.ocd       <= OCD_EXIT;
      st_r.cap       <= CAP_IDLE;
      st_r.beat      <= 2'h0;
      st_r.code      <= 4'h0;
      st_r.pull_up   <= STEP_DEFAULT;
      st_r.pull_down <= STEP_DEFAULT;
      st_r.drv       <= drive_for(OCD_EXIT);
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign ext_one_out                    = st_r.ext_one;
  assign ext_two_out                    = st_r.ext_two;
  assign ext_three_out                  = st_r.ext_three;
  assign burst_length_out               = st_r.base_mode[BL_LSB +: 3];
  assign dll_active_out                 = st_r.dll_on;
  assign half_strength_out              = st_r.ext_one[HALF_BIT];
  assign rtt_out                        = st_r.rtt;
  assign additive_latency_out           = st_r.ext_one[AL_LSB +: 3];
  assign strobe_compl_disable_out       = st_r.ext_one[STRB_DIS_BIT];
  assign fast_refresh_out               = st_r.ext_two[FAST_SR_BIT];
  assign partial_array_self_refresh_out = st_r.ext_two[2:0];
  assign retention_lost_out             = st_r.lost;
  assign self_refresh_out               = st_r.self_ref;
  assign ocd_mode_out                   = st_r.ocd;
  assign pull_up_out                    = st_r.pull_up;
  assign pull_down_out                  = st_r.pull_down;
  assign drive_out                      = st_r.drv;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_adj_start;
    st_r.ocd == OCD_ADJUST && st_r.cap == CAP_IDLE && wr_data && !wr_one;
  endsequence

  sequence s_up_code;
    (!wr_one && !dq_in[0]) [*3] ##1 (!wr_one && dq_in[0] && st_r.pull_up != STEP_MAX);
  endsequence

  sequence s_dn_code;
    (!wr_one && dq_in[0] && st_r.pull_down != STEP_MIN) ##1 (!wr_one && !dq_in[0]) [*3];
  endsequence

  AST_ONE_LOAD: assert property (wr_one |=> ext_one_out == $past(cmd_in.addr))
    else $error("register one not loaded");
  AST_TWO_LOAD: assert property (wr_two |=> ext_two_out == $past(cmd_in.addr))
    else $error("register two not loaded");
  AST_SR_DLL: assert property (self_refresh_out |-> !dll_active_out)
    else $error("dll active in self refresh");
  AST_SR_EXIT: assert property (self_refresh_out && cmd_in.cke |=> !self_refresh_out)
    else $error("self refresh not exited");
  AST_DRIVE_HIGH: assert property (ocd_mode_out == OCD_DRIVE_HIGH |->
    drive_out.dq == 16'hffff && drive_out.dqs_n == 2'h0 && !drive_out.dq_oe_n)
    else $error("drive high levels wrong");
  AST_DRIVE_LOW: assert property (ocd_mode_out == OCD_DRIVE_LOW |->
    drive_out.dq == 16'h0000 && drive_out.dqs_n == 2'h3 && !drive_out.dqs_oe_n)
    else $error("drive low levels wrong");
  AST_OCD_CODE: assert property (wr_one && ocd_code == OCD_DRV0_C |=>
    ocd_mode_out == OCD_DRIVE_LOW)
    else $error("calibration code not decoded");
  AST_DEF_STEP: assert property (wr_one && ocd_code == OCD_DEF_C |=>
    pull_up_out == STEP_DEFAULT && pull_down_out == STEP_DEFAULT)
    else $error("default step not loaded");
  AST_SR_ENTRY: assert property (sr_entry |=> self_refresh_out && !dll_active_out)
    else $error("self refresh not entered");
  AST_ADJ_UP: assert property (s_adj_start ##1 s_up_code |=>
    pull_up_out == $past(pull_up_out) + 4'h1)
    else $error("pull-up step not applied");
  AST_ADJ_DN: assert property (s_adj_start ##1 s_dn_code |=>
    pull_down_out == $past(pull_down_out) - 4'h1)
    else $error("pull-down step not applied");
  AST_SAT: assert property ($past(pull_up_out) == STEP_MAX |-> pull_up_out != STEP_MIN)
    else $error("pull-up wrapped");
  AST_KEEP: assert property (wr_one && ocd_code == OCD_EXIT_C |=>
    $stable(pull_up_out) && $stable(pull_down_out))
    else $error("strength changed on exit");
  AST_RTT: assert property (wr_one && cmd_in.addr[RTT_HI_BIT]
    && cmd_in.addr[RTT_LO_BIT] |=> rtt_out == RTT_50)
    else $error("termination decode wrong");

endmodule

// ---- verification/dxmr_ctrl_model.sv ----
module dxmr_ctrl_model
  import dxmr_pkg::*;
#(
  parameter int MRD_CYC = 2
)(
  input  wire logic    clk_in,
  output dxmr_cmd_type cmd_out,
  output logic [15:0]  dq_out
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam dxmr_cmd_type NOP = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0, 13'h0000};

  initial begin
    cmd_out = NOP;
    dq_out  = 16'h0000;
  end

  ////////////////////////////////////////////////////////////
  // released data lines toggle so no stale code is seen
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_in);
      cmd_out <= NOP;
      dq_out  <= ~dq_out;
    end
  endtask

  // banks stay precharged and cke high; spacing after each write
  task automatic issue(input logic we_n, input logic [1:0] ba, input logic [12:0] a);
    @(posedge clk_in);
    cmd_out <= '{1'b1, 1'b0, 1'b0, 1'b0, we_n, ba, a};
    idle(MRD_CYC);
  endtask

  task automatic mode_wr(input logic [1:0] ba, input logic [12:0] a);
    issue(1'b0, ba, a);
  endtask

  // adjust entry, write, code on all dq, then calibration exit
  task automatic adjust(input logic [2:0] al, input logic [3:0] code);
    mode_wr(2'h1, {3'h0, OCD_ADJ_C, 1'b0, al, 3'h0});
    @(posedge clk_in);
    cmd_out <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 13'h0000};
    for (int i = 3; i >= 0; i--) begin
      @(posedge clk_in);
      cmd_out <= NOP;
      dq_out  <= {16{code[i]}};
    end
    idle(2);
    mode_wr(2'h1, {3'h0, OCD_EXIT_C, 1'b0, al, 3'h0});
  endtask

  task automatic sr_enter();
    @(posedge clk_in);
    cmd_out <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 13'h0000};
    @(posedge clk_in);
  endtask

  task automatic sr_exit();
    @(posedge clk_in);
    cmd_out <= NOP;
    idle(2);
  endtask
endmodule

// ---- verification/tb_top.sv ----
module tb_top
  import dxmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic           clk_in;
  logic           rstn_in;
  dxmr_cmd_type   cmd;
  logic [15:0]    dq;
  logic [12:0]    e1, e2, e3, a;
  logic [2:0]     bl, al, part_sr;
  logic           dll, half, sdis, fast, lost, sr;
  dxmr_rtt_type   rtt;
  dxmr_ocd_type   ocd;
  logic [3:0]     pu, pd, c;
  logic [7:0]     s;
  dxmr_drive_type drv;
  int             fails = 0;
  int             n_compared = 0;
  int             cyc = 0;
  logic [2:0]     oc [4] = '{OCD_DRV1_C, OCD_DRV0_C, OCD_DEF_C, 3'h3};
  dxmr_ocd_type   om [4] = '{OCD_DRIVE_HIGH, OCD_DRIVE_LOW, OCD_DEFAULT, OCD_EXIT};
  dxmr_drive_type dx [2] = '{'{16'hffff, 1'b0, 2'h3, 2'h0, 1'b0},
                             '{16'h0000, 1'b0, 2'h0, 2'h3, 1'b0}};

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // saturating step counters, limits 0 and 15
  function automatic logic [7:0] step(input logic [3:0] k, input logic [7:0] v);
    logic [3:0] u;
    logic [3:0] d;
    u = v[7:4];
    d = v[3:0];
    if (k inside {4'h1, 4'h5, 4'h9} && u != 4'hf) u++;
    if (k inside {4'h2, 4'h6, 4'ha} && u != 4'h0) u--;
    if (k inside {4'h4, 4'h5, 4'h6} && d != 4'hf) d++;
    if (k inside {4'h8, 4'h9, 4'ha} && d != 4'h0) d--;
    return {u, d};
  endfunction

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      $display("unexpected at %0t: run timed out", $time);
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////
  dxmr_ctrl_model u_ctrl (.clk_in(clk_in), .cmd_out(cmd), .dq_out(dq));

  dxmr_core u_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .cmd_in(cmd), .dq_in(dq),
    .ext_one_out(e1), .ext_two_out(e2), .ext_three_out(e3),
    .burst_length_out(bl), .dll_active_out(dll), .half_strength_out(half),
    .rtt_out(rtt), .additive_latency_out(al), .strobe_compl_disable_out(sdis),
    .fast_refresh_out(fast), .partial_array_self_refresh_out(part_sr),
    .retention_lost_out(lost), .self_refresh_out(sr), .ocd_mode_out(ocd),
    .pull_up_out(pu), .pull_down_out(pd), .drive_out(drv)
  );

  initial begin
    rstn_in = 1'b0;
    void'($urandom(32'hfc97d0fa));
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    #1 chk({ocd, pu, pd, dll, lost, drv},
           {OCD_EXIT, STEP_DEFAULT, STEP_DEFAULT, 2'b00, 22'h000021}, "reset");
    u_ctrl.mode_wr(2'h0, 13'h0002);
    #1 chk(bl, 3'h2, "burst");
    for (int i = 0; i < 8; i++) begin
      a = 13'($urandom) & 13'h1c7f;
      u_ctrl.mode_wr(2'h1, a);
      #1 chk({e1, half, al, sdis, dll, rtt},
             {a, a[1], a[5:3], a[10], ~a[0], a[6], a[2]}, "reg one");
      u_ctrl.issue(1'b1, 2'h1, ~a);
      #1 chk(e1, a, "refresh kept");
      a = 13'($urandom) & 13'h0087;
      u_ctrl.mode_wr(2'h2, a);
      #1 chk({e2, fast, part_sr}, {a, a[7], a[2:0]}, "reg two");
    end
    u_ctrl.mode_wr(2'h3, 13'h0000);
    #1 chk(e3, 13'h0000, "reg three");
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      u_ctrl.mode_wr(2'h1, {3'h0, oc[k], 7'h00});
      #1 chk(ocd, om[k], "ocd mode");
      if (k < 2) chk(drv, dx[k], "drive");
      u_ctrl.mode_wr(2'h1, 13'h0000);
      #1 chk({ocd, drv.dq_oe_n, drv.dqs_oe_n}, {OCD_EXIT, 2'b11}, "exit");
    end
    $display("test drive modes done");
    s = {STEP_DEFAULT, STEP_DEFAULT};
    for (int i = 0; i < 66; i++) begin
      c = (i < 9) ? 4'h5 : (i < 26) ? 4'ha : 4'($urandom);
      u_ctrl.adjust(3'($urandom % 6), c);
      s = step(c, s);
      #1 chk({pu, pd}, s, "steps");
    end
    u_ctrl.mode_wr(2'h1, {3'h0, OCD_DEF_C, 7'h00});
    u_ctrl.mode_wr(2'h1, 13'h0000);
    #1 chk({pu, pd}, {STEP_DEFAULT, STEP_DEFAULT}, "default");
    $display("test adjust done");
    for (int k = 0; k < 2; k++) begin
      u_ctrl.mode_wr(2'h2, k ? 13'h0085 : 13'h0000);
      u_ctrl.mode_wr(2'h1, 13'h0000);
      u_ctrl.sr_enter();
      #1 chk({sr, dll, lost, fast}, {2'b10, k[0], k[0]}, "sr entry");
      u_ctrl.sr_exit();
      #1 chk({sr, dll, lost}, {2'b01, k[0]}, "sr exit");
      u_ctrl.idle(200);
    end
    $display("test self refresh done");
    finish_test();
  end
endmodule
